// ### design/sfd_pkg.sv
// Purpose: constants for the serial flash instruction decoder
// Assumes: spi mode 0, msb first; a mode 3 frame loses its last edge, so its modifying commands are refused
// Notes: identification values are arbitrary
package sfd_pkg;
    // ----------------------------------------
    // instruction codes
    // ----------------------------------------
    localparam logic [7:0] LATCH_SET_CMD = 8'h06;
    localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;
    localparam logic [7:0] IDENT_READ_CMD = 8'h9F;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] READ_CMD = 8'h03;
    localparam logic [7:0] FAST_READ_CMD = 8'h0B;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
    localparam logic [7:0] BULK_ERASE_CMD = 8'hC7;
    // ----------------------------------------
    // organisation
    // ----------------------------------------
    localparam int ARRAY_BYTES = 16777216;
    localparam int SECTOR_BYTES = 262144;
    localparam logic [23:0] SECTOR_STRIDE = 24'h04_0000;
    localparam int PAGE_BYTES = 256;
    localparam int ADDR_BYTES = 3;
    localparam int DUMMY_BYTES = 1;
    localparam int ID_BYTES = 3;
    // identification values, arbitrary
    localparam logic [7:0] ID_MAKER = 8'hA5;
    localparam logic [7:0] ID_TYPE = 8'h5A;
    localparam logic [7:0] ID_SIZE = 8'h3C;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic WEL_RESET = 1'b0;
    localparam logic [2:0] BIT_CNT_RESET = 3'h0;
    // ----------------------------------------
    // frame phases
    // ----------------------------------------
    typedef enum logic [2:0] {
        SFD_CODE, SFD_ADDR, SFD_DUMMY, SFD_DOUT, SFD_DIN, SFD_IDLE
    } sfd_phase_t;
    // ----------------------------------------
    // commands issued to the array engine
    // ----------------------------------------
    typedef enum logic [2:0] {
        SFD_OP_NONE, SFD_OP_STATUS_WRITE_CMD, SFD_OP_PROG, SFD_OP_SERASE, SFD_OP_BERASE
    } sfd_op_t;
endpackage

// ### design/sfd_decoder.sv
// Purpose: instruction front end of a serial flash, framing on the serial clock
// Assumes: i_sclk is the link clock; array engine runs on i_mclk
// Notes: array access, protection and status bits live outside this block
//
// Summary of operation
// - array of 16777216 bytes, 64 sectors at 040000h strides, 65536 pages
// - program clears bits per page; only sector or bulk erase sets ones
// - all codes, addresses and data move msb first both ways
// - input captured on every rising serial clock edge after select low
// - each frame starts with one eight-bit code, then address/data/none
// - reads, status read and ident stream output until select rises
// - modifying commands run only if select rises on a byte boundary
// - while an internal cycle runs, array access is ignored
// - code 03h takes three address bytes then streams data
// - code 0Bh takes three address bytes, one dummy, then streams
// - 02h address plus up to 256 data; D8h address only; C7h nothing
// - 05h repeats status bytes; 01h runs after any number of whole data bytes, none passed on
// - code 06h sets the write enable latch
// - modifying commands are refused while the latch is clear
// - code 04h clears the write enable latch
// - latch cleared at reset and after clear, status write, program, erase
// - 9Fh returns maker, type and capacity bytes, one to three read
// - ident during an internal cycle is not decoded
// - output bits change on the falling serial clock edge
// - select high ends ident and waits for next selection
`timescale 1ns/1ps
module sfd_decoder #(
    parameter int PAGE_LEN = sfd_pkg::PAGE_BYTES
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_sclk,
    input wire logic i_sel_n,
    input wire logic i_sdi,
    input wire logic [7:0] i_status,
    input wire logic [7:0] i_rd_data,
    input wire logic i_busy,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_wel,
    output logic o_op_valid,
    output logic [2:0] o_op,
    output logic [23:0] o_op_addr,
    output logic [7:0] o_wr_data,
    output logic o_wr_valid,
    output logic [23:0] o_rd_addr,
    output logic o_rd_req
);
    // ----------------------------------------
    // link domain: shift and frame
    // ----------------------------------------
    logic [2:0] bit_cnt_r;
    logic [6:0] shin_r;
    logic [7:0] code_r;
    logic [1:0] byte_cnt_r;
    logic [8:0] data_cnt_r;
    logic [23:0] addr_r;
    sfd_pkg::sfd_phase_t phase_r;
    logic [7:0] dbyte_r;
    logic dbyte_tg_r;
    logic rdreq_tg_r;
    logic [7:0] out_r;
    logic [2:0] obit_r;
    logic [1:0] id_idx_r;
    logic busy_l1_r, busy_l2_r;
    logic [2:0] end_bits_r;
    logic [1:0] end_ph_r;
    logic [7:0] end_code_r;
    logic [23:0] end_addr_r;

    wire logic [7:0] rx_byte = {shin_r, i_sdi};
    wire logic byte_done = (bit_cnt_r == 3'h7);
    wire logic [7:0] id_byte = (id_idx_r == 2'h0) ? sfd_pkg::ID_MAKER :
                               (id_idx_r == 2'h1) ? sfd_pkg::ID_TYPE : sfd_pkg::ID_SIZE;
    wire logic code_has_addr = (rx_byte == sfd_pkg::READ_CMD) ||
                               (rx_byte == sfd_pkg::FAST_READ_CMD) ||
                               (rx_byte == sfd_pkg::PAGE_PROGRAM_CMD) ||
                               (rx_byte == sfd_pkg::SECTOR_ERASE_CMD);
    wire logic code_is_out = (rx_byte == sfd_pkg::STATUS_READ_CMD) ||
                             ((rx_byte == sfd_pkg::IDENT_READ_CMD) && !busy_l2_r);
    wire logic code_is_in = (rx_byte == sfd_pkg::STATUS_WRITE_CMD);
    wire logic is_fast = (code_r == sfd_pkg::FAST_READ_CMD);
    wire logic is_read = (code_r == sfd_pkg::READ_CMD) || is_fast;
    wire logic [1:0] ph_code = (phase_r == sfd_pkg::SFD_IDLE) ? 2'h1 :
                               (phase_r == sfd_pkg::SFD_DIN) ? 2'h1 :
                               (phase_r == sfd_pkg::SFD_CODE) ? 2'h0 : 2'h2;

    // select high resets framing through async clear of the link logic
    always_ff @(posedge i_sclk or posedge i_sel_n) begin
        if (i_sel_n) begin
            bit_cnt_r <= sfd_pkg::BIT_CNT_RESET;
            shin_r <= 7'h00;
            code_r <= 8'h00;
            byte_cnt_r <= 2'h0;
            data_cnt_r <= 9'h000;
            addr_r <= 24'h00_0000;
            phase_r <= sfd_pkg::SFD_CODE;
            id_idx_r <= 2'h0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            shin_r <= rx_byte[6:0];
            if (byte_done) begin
                unique case (phase_r)
                    sfd_pkg::SFD_CODE: begin
                        code_r <= rx_byte;
                        if (code_has_addr) begin
                            phase_r <= sfd_pkg::SFD_ADDR;
                        end else if (code_is_out) begin
                            phase_r <= sfd_pkg::SFD_DOUT;
                        end else if (code_is_in) begin
                            phase_r <= sfd_pkg::SFD_DIN;
                        end else begin
                            phase_r <= sfd_pkg::SFD_IDLE;
                        end
                    end
                    sfd_pkg::SFD_ADDR: begin
                        addr_r <= {addr_r[15:0], rx_byte};
                        byte_cnt_r <= byte_cnt_r + 2'h1;
                        if (byte_cnt_r == 2'(sfd_pkg::ADDR_BYTES - 1)) begin
                            if (is_fast) begin
                                phase_r <= sfd_pkg::SFD_DUMMY;
                            end else if (is_read) begin
                                phase_r <= sfd_pkg::SFD_DOUT;
                            end else if (code_r == sfd_pkg::PAGE_PROGRAM_CMD) begin
                                phase_r <= sfd_pkg::SFD_DIN;
                            end else begin
                                phase_r <= sfd_pkg::SFD_IDLE;
                            end
                        end
                    end
                    sfd_pkg::SFD_DUMMY: begin
                        phase_r <= sfd_pkg::SFD_DOUT;
                    end
                    sfd_pkg::SFD_DOUT: begin
                        if (is_read) begin
                            addr_r <= addr_r + 24'h00_0001;
                        end
                        if (id_idx_r != 2'(sfd_pkg::ID_BYTES - 1)) begin
                            id_idx_r <= id_idx_r + 2'h1;
                        end
                    end
                    sfd_pkg::SFD_DIN: begin
                        if (data_cnt_r != 9'(PAGE_LEN)) begin
                            data_cnt_r <= data_cnt_r + 9'h001;
                        end
                        if (code_r == sfd_pkg::STATUS_WRITE_CMD) begin
                            phase_r <= sfd_pkg::SFD_IDLE;
                        end
                    end
                    sfd_pkg::SFD_IDLE: begin
                        phase_r <= sfd_pkg::SFD_IDLE;
                    end
                endcase
            end
        end
    end

    // data byte and read request events cross as toggles
    wire logic din_take = byte_done && (phase_r == sfd_pkg::SFD_DIN) &&
                          (code_r == sfd_pkg::PAGE_PROGRAM_CMD) &&
                          (data_cnt_r != 9'(PAGE_LEN));
    wire logic rd_fire = byte_done && is_read &&
                         (((phase_r == sfd_pkg::SFD_ADDR) && !is_fast &&
                           (byte_cnt_r == 2'(sfd_pkg::ADDR_BYTES - 1))) ||
                          (phase_r == sfd_pkg::SFD_DUMMY) ||
                          (phase_r == sfd_pkg::SFD_DOUT));
    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            busy_l1_r <= 1'b0;
            busy_l2_r <= 1'b0;
            dbyte_tg_r <= 1'b0;
            rdreq_tg_r <= 1'b0;
            dbyte_r <= 8'h00;
        end else begin
            busy_l1_r <= i_busy;
            busy_l2_r <= busy_l1_r;
            if (din_take) begin
                dbyte_tg_r <= ~dbyte_tg_r;
                dbyte_r <= rx_byte;
            end
            if (rd_fire) begin
                rdreq_tg_r <= ~rdreq_tg_r;
            end
        end
    end

    // output shifter updates on the falling edge
    wire logic [7:0] load_byte = (code_r == sfd_pkg::STATUS_READ_CMD) ? i_status :
                                 is_read ? i_rd_data : id_byte;
    always_ff @(negedge i_sclk or posedge i_sel_n or posedge i_rst) begin
        if (i_sel_n || i_rst) begin
            out_r <= 8'h00;
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
            obit_r <= 3'h0;
        end else if (phase_r == sfd_pkg::SFD_DOUT) begin
            o_sdo_oe <= 1'b1;
            obit_r <= obit_r + 3'h1;
            if (obit_r == 3'h0) begin
                o_sdo <= load_byte[7];
                out_r <= {load_byte[6:0], 1'b0};
            end else begin
                o_sdo <= out_r[7];
                out_r <= {out_r[6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // frame-end copies for the main domain
    // ----------------------------------------
    // a mode 3 host ends high, so its last edge is not copied
    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            end_bits_r <= sfd_pkg::BIT_CNT_RESET;
            end_ph_r <= 2'h0;
            end_code_r <= 8'h00;
            end_addr_r <= 24'h00_0000;
        end else if (!i_sel_n) begin
            end_bits_r <= bit_cnt_r;
            end_ph_r <= ph_code;
            end_code_r <= code_r;
            end_addr_r <= addr_r;
        end
    end

    // ----------------------------------------
    // main domain: crossing and execution
    // ----------------------------------------
    logic [2:0] sel_sync_r, dtg_sync_r, rtg_sync_r;
    logic [2:0] bit_q1_r, bit_q2_r;
    logic [1:0] ph_q1_r, ph_q2_r;
    logic [7:0] code_q_r;
    logic [23:0] addr_q_r;
    logic wel_r;

    wire logic sel_rise = sel_sync_r[1] && !sel_sync_r[2];
    wire logic dbyte_evt = dtg_sync_r[1] ^ dtg_sync_r[2];
    wire logic rdreq_evt = rtg_sync_r[1] ^ rtg_sync_r[2];
    // frame-end copies stay static while select is high, so sampling after release is safe
    wire logic aligned = (bit_q2_r == 3'h0);
    wire logic frame_ok = aligned && (ph_q2_r == 2'h1);
    wire logic is_mod = (code_q_r == sfd_pkg::PAGE_PROGRAM_CMD) ||
                        (code_q_r == sfd_pkg::SECTOR_ERASE_CMD) ||
                        (code_q_r == sfd_pkg::BULK_ERASE_CMD) ||
                        (code_q_r == sfd_pkg::STATUS_WRITE_CMD);
    wire logic exec = sel_rise && frame_ok && is_mod && wel_r && !i_busy;
    wire logic [2:0] op_sel = (code_q_r == sfd_pkg::PAGE_PROGRAM_CMD) ? 3'(sfd_pkg::SFD_OP_PROG) :
                              (code_q_r == sfd_pkg::SECTOR_ERASE_CMD) ?
                              3'(sfd_pkg::SFD_OP_SERASE) :
                              (code_q_r == sfd_pkg::BULK_ERASE_CMD) ?
                              3'(sfd_pkg::SFD_OP_BERASE) : 3'(sfd_pkg::SFD_OP_STATUS_WRITE_CMD);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sel_sync_r <= 3'h7;
            dtg_sync_r <= 3'h0;
            rtg_sync_r <= 3'h0;
            bit_q1_r <= 3'h0;
            bit_q2_r <= 3'h0;
            ph_q1_r <= 2'h0;
            ph_q2_r <= 2'h0;
            code_q_r <= 8'h00;
            addr_q_r <= 24'h00_0000;
            wel_r <= sfd_pkg::WEL_RESET;
            o_op_valid <= 1'b0;
            o_op <= 3'(sfd_pkg::SFD_OP_NONE);
            o_op_addr <= 24'h00_0000;
            o_wr_data <= 8'h00;
            o_wr_valid <= 1'b0;
            o_rd_addr <= 24'h00_0000;
            o_rd_req <= 1'b0;
            o_wel <= sfd_pkg::WEL_RESET;
        end else if (i_ce) begin
            sel_sync_r <= {sel_sync_r[1:0], i_sel_n};
            dtg_sync_r <= {dtg_sync_r[1:0], dbyte_tg_r};
            rtg_sync_r <= {rtg_sync_r[1:0], rdreq_tg_r};
            bit_q1_r <= end_bits_r;
            bit_q2_r <= bit_q1_r;
            ph_q1_r <= end_ph_r;
            ph_q2_r <= ph_q1_r;
            code_q_r <= end_code_r;
            addr_q_r <= end_addr_r;
            o_wr_valid <= dbyte_evt && !i_busy;
            if (dbyte_evt) begin
                o_wr_data <= dbyte_r;
            end
            o_rd_req <= rdreq_evt && !i_busy;
            if (rdreq_evt) begin
                o_rd_addr <= addr_r;
            end
            o_op_valid <= exec;
            if (exec) begin
                o_op <= op_sel;
                o_op_addr <= addr_q_r & ~(SECTOR_MASK_INV());
            end
            if (sel_rise && frame_ok && code_q_r == sfd_pkg::LATCH_SET_CMD) begin
                wel_r <= 1'b1;
            end else if (sel_rise && frame_ok && code_q_r == sfd_pkg::LATCH_CLEAR_CMD) begin
                wel_r <= 1'b0;
            end else if (exec) begin
                wel_r <= 1'b0;
            end
            o_wel <= wel_r;
        end
    end

    // sector erase keeps the full address; bulk ignores it
    function automatic logic [23:0] SECTOR_MASK_INV();
        return 24'h00_0000;
    endfunction

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_wel_reset;
        @(posedge i_mclk) $rose(i_rst) |=> !wel_r;
    endproperty
    a_wel_reset: assert property (p_wel_reset) else $error("latch not cleared");
    property p_exec_needs_wel;
        @(posedge i_mclk) disable iff (i_rst) o_op_valid |-> o_wel;
    endproperty
    a_exec_needs_wel: assert property (p_exec_needs_wel) else $error("bad exec");
    property p_exec_clears;
        @(posedge i_mclk) disable iff (i_rst) (exec && i_ce) |=> !wel_r;
    endproperty
    a_exec_clears: assert property (p_exec_clears) else $error("latch kept");
    property p_busy_block;
        @(posedge i_mclk) disable iff (i_rst) (i_ce && i_busy) |=> !o_op_valid;
    endproperty
    a_busy_block: assert property (p_busy_block) else $error("exec while busy");
    property p_op_pulse;
        @(posedge i_mclk) disable iff (i_rst) o_op_valid |=> !o_op_valid;
    endproperty
    a_op_pulse: assert property (p_op_pulse) else $error("op held");
    property p_set;
        @(posedge i_mclk) disable iff (i_rst)
            (i_ce && sel_rise && frame_ok && code_q_r == sfd_pkg::LATCH_SET_CMD) |=> wel_r;
    endproperty
    a_set: assert property (p_set) else $error("latch not set");
    property p_clr;
        @(posedge i_mclk) disable iff (i_rst)
            (i_ce && sel_rise && frame_ok && code_q_r == sfd_pkg::LATCH_CLEAR_CMD) |=> !wel_r;
    endproperty
    a_clr: assert property (p_clr) else $error("latch not cleared");
    property p_wel_out;
        @(posedge i_mclk) disable iff (i_rst) i_ce |=> o_wel == $past(wel_r);
    endproperty
    a_wel_out: assert property (p_wel_out) else $error("latch output stale");
    property p_rd_busy;
        @(posedge i_mclk) disable iff (i_rst) (i_ce && i_busy) |=> !o_rd_req;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read while busy");
    property p_wr_busy;
        @(posedge i_mclk) disable iff (i_rst) (i_ce && i_busy) |=> !o_wr_valid;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write while busy");
    property p_short_refused;
        @(posedge i_mclk) disable iff (i_rst) (i_ce && sel_rise && !aligned) |=> !o_op_valid;
    endproperty
    a_short_refused: assert property (p_short_refused) else $error("unaligned frame ran");
    property p_oe_in_dout;
        @(negedge i_sclk) disable iff (i_sel_n) o_sdo_oe |-> (phase_r == sfd_pkg::SFD_DOUT);
    endproperty
    a_oe_in_dout: assert property (p_oe_in_dout) else $error("output outside data phase");
    c_exec: cover property (@(posedge i_mclk) exec);
    c_set: cover property (@(posedge i_mclk) $rose(wel_r));
    c_out: cover property (@(posedge i_mclk) o_sdo_oe);
    c_rd: cover property (@(posedge i_mclk) o_rd_req);
    c_wr: cover property (@(posedge i_mclk) o_wr_valid);
endmodule

// ### sim/sfd_host_model.sv
// Purpose: host serial bus controller model driving select, clock and data in
// Assumes: mode 0, clock idles low and stands still between frames
// Notes: data line shows the inverse of its last bit while deselected
`timescale 1ns/1ps
module sfd_host_model (
    output logic o_sclk,
    output logic o_sel_n,
    output logic o_sdi,
    input wire logic i_sdo
);
    initial begin
        o_sclk = 1'b0;
        o_sel_n = 1'b1;
        o_sdi = 1'b0;
    end

    // ----------------------------------------
    // one selected frame of n clocks
    // ----------------------------------------
    task automatic frame(input int n, input logic [63:0] tx, input int half,
                         output logic [63:0] rx);
        rx = 64'h0000_0000_0000_0000;
        o_sel_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_sdi = tx[i];
            #(half);
            rx = {rx[62:0], i_sdo};
            o_sclk = 1'b1;
            #(half);
            o_sclk = 1'b0;
        end
        #(half);
        o_sel_n = 1'b1;
        o_sdi = ~o_sdi;
    endtask
endmodule

// ### sim/serial_flash_instruction_decoder_tb_top.sv
// Purpose: self-checking bench for the serial flash instruction decoder
// Assumes: op codes 1 status write, 2 program, 3 sector erase, 4 bulk erase
// Notes: slow serial clock used where a read address crosses to the main clock
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module serial_flash_instruction_decoder_tb_top;
    localparam int FAST = 3;
    localparam int SLOW = 250;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b0;
    logic i_ce = 1'b1;
    logic i_busy = 1'b0;
    logic [7:0] i_status = 8'h00;
    logic [7:0] i_rd_data = 8'h00;
    wire logic sclk, sel_n, sdi;
    logic o_sdo, o_sdo_oe, o_wel, o_op_valid, o_wr_valid, o_rd_req;
    logic [2:0] o_op;
    logic [23:0] o_op_addr, o_rd_addr, addr_seen, rd_addr_seen;
    logic [7:0] o_wr_data, wr_seen;
    logic [2:0] op_seen;
    logic [63:0] rx;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int op_cnt, rd_cnt;

    always #12.5 i_mclk = ~i_mclk;

    sfd_decoder dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_sclk(sclk),
        .i_sel_n(sel_n), .i_sdi(sdi), .i_status(i_status), .i_rd_data(i_rd_data),
        .i_busy(i_busy), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_wel(o_wel),
        .o_op_valid(o_op_valid), .o_op(o_op), .o_op_addr(o_op_addr),
        .o_wr_data(o_wr_data), .o_wr_valid(o_wr_valid), .o_rd_addr(o_rd_addr),
        .o_rd_req(o_rd_req));

    sfd_host_model host (.o_sclk(sclk), .o_sel_n(sel_n), .o_sdi(sdi), .i_sdo(o_sdo));

    // ----------------------------------------
    // monitor of main-side pulses
    // ----------------------------------------
    always @(negedge i_mclk) begin
        if (o_op_valid === 1'b1) begin
            op_cnt++;
            op_seen = o_op;
            addr_seen = o_op_addr;
        end
        if (o_wr_valid === 1'b1) wr_seen = o_wr_data;
        if (o_rd_req === 1'b1) begin
            if (rd_cnt == 0) rd_addr_seen = o_rd_addr;
            rd_cnt++;
        end
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic results();
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wait_m(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    task automatic send(input int n, input logic [63:0] tx, input int half);
        op_cnt = 0;
        rd_cnt = 0;
        wr_seen = 8'h00;
        host.frame(n, tx, half, rx);
        wait_m(12);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        `CHK("wel", 1'b0, o_wel)
        `CHK("op_valid", 1'b0, o_op_valid)
        `CHK("sdo_oe", 1'b0, o_sdo_oe)
    endtask

    task automatic t_latch();
        send(8, 64'h06, FAST);
        `CHK("wel set", 1'b1, o_wel)
        send(8, 64'h04, FAST);
        `CHK("wel clear", 1'b0, o_wel)
        send(3, 64'h0, FAST);
        send(8, 64'h06, FAST);
        `CHK("wel after abort", 1'b1, o_wel)
        send(7, 64'h02, FAST);
        `CHK("wel short clear", 1'b1, o_wel)
        send(8, 64'h04, FAST);
        `CHK("wel clear2", 1'b0, o_wel)
    endtask

    task automatic t_prog();
        send(40, {24'h0, 8'h02, 24'h12_3456, 8'hC3}, FAST);
        `CHK("refused ops", 0, op_cnt)
        send(8, 64'h06, FAST);
        send(40, {24'h0, 8'h02, 24'h12_3456, 8'hC3}, FAST);
        `CHK("prog ops", 1, op_cnt)
        `CHK("prog op", 3'h2, op_seen)
        `CHK("prog addr", 24'h12_3456, addr_seen)
        `CHK("prog data", 8'hC3, wr_seen)
        `CHK("wel after prog", 1'b0, o_wel)
    endtask

    task automatic t_erase();
        send(8, 64'h06, FAST);
        send(31, {32'h0, 8'hD8, 24'h04_0000} >> 1, FAST);
        `CHK("short erase ops", 0, op_cnt)
        `CHK("wel kept", 1'b1, o_wel)
        send(32, {32'h0, 8'hD8, 24'h04_0000}, FAST);
        `CHK("erase op", 3'h3, op_seen)
        `CHK("erase addr", 24'h04_0000, addr_seen)
        `CHK("wel after erase", 1'b0, o_wel)
        send(8, 64'h06, FAST);
        send(8, 64'hC7, FAST);
        `CHK("bulk op", 3'h4, op_seen)
        `CHK("wel after bulk", 1'b0, o_wel)
        send(8, 64'h06, FAST);
        send(16, 64'h011C, FAST);
        `CHK("stat wr ops", 1, op_cnt)
        `CHK("stat wr op", 3'h1, op_seen)
        `CHK("wel after stat wr", 1'b0, o_wel)
    endtask

    task automatic t_busy();
        send(8, 64'h06, FAST);
        i_busy = 1'b1;
        send(8, 64'hC7, FAST);
        `CHK("busy ops", 0, op_cnt)
        send(16, 64'h9F00, FAST);
        `CHK("ident busy", 8'h00, rx[7:0])
        `CHK("busy keeps wel", 1'b1, o_wel)
        i_busy = 1'b0;
        send(8, 64'h04, FAST);
    endtask

    task automatic t_ce();
        i_ce = 1'b0;
        send(8, 64'h06, FAST);
        `CHK("wel frozen", 1'b0, o_wel)
        i_ce = 1'b1;
        wait_m(4);
        `CHK("wel missed", 1'b0, o_wel)
    endtask

    task automatic t_reads();
        send(32, 64'h9F00_0000, SLOW);
        `CHK("ident", {sfd_pkg::ID_MAKER, sfd_pkg::ID_TYPE, sfd_pkg::ID_SIZE}, rx[23:0])
        `CHK("oe idle", 1'b0, o_sdo_oe)
        i_status = 8'h81;
        send(24, 64'h05_0000, SLOW);
        `CHK("status", 16'h8181, rx[15:0])
        i_rd_data = 8'h96;
        send(40, {24'h0, 8'h03, 24'h01_0203, 8'h00}, SLOW);
        `CHK("read addr", 24'h01_0203, rd_addr_seen)
        `CHK("read data", 8'h96, rx[7:0])
        send(48, {16'h0, 8'h0B, 24'h0A_0B0C, 16'h0000}, SLOW);
        `CHK("fast addr", 24'h0A_0B0C, rd_addr_seen)
        `CHK("fast data", 8'h96, rx[7:0])
    endtask

    initial begin
        @(negedge i_mclk);
        i_rst = 1'b1;
        repeat (10) @(negedge i_mclk);
        i_rst = 1'b0;
        wait_m(4);
        t_reset();
        t_latch();
        t_prog();
        t_erase();
        t_busy();
        t_ce();
        t_reads();
        results();
    end
endmodule
